// >>> rtl/pdl_pkg.sv
// Package for the port data latch bank: register offsets, implemented-bit masks, reset value.
// Assumes an 8-bit processor data path with 16-bit byte addresses.
package pdl_pkg;

	localparam int unsigned PDL_NPORT = 11;

	typedef logic [7:0]  pdl_byte_t;
	typedef logic [15:0] pdl_addr_t;
	typedef logic [3:0]  pdl_idx_t;

	localparam pdl_addr_t LINE_DATA_0_OFS  = 16'hff00;
	localparam pdl_addr_t LINE_DATA_1_OFS  = 16'hff01;
	localparam pdl_addr_t LINE_DATA_3_OFS  = 16'hff03;
	localparam pdl_addr_t LINE_DATA_4_OFS  = 16'hff04;
	localparam pdl_addr_t LINE_DATA_5_OFS  = 16'hff05;
	localparam pdl_addr_t LINE_DATA_6_OFS  = 16'hff06;
	localparam pdl_addr_t LINE_DATA_7_OFS  = 16'hff07;
	localparam pdl_addr_t LINE_DATA_8_OFS  = 16'hff08;
	localparam pdl_addr_t LINE_DATA_9_OFS  = 16'hff09;
	localparam pdl_addr_t LINE_DATA_12_OFS = 16'hff0c;
	localparam pdl_addr_t LINE_DATA_13_OFS = 16'hff0d;

	// Bits with a pin behind them, per register, in bank index order
	localparam pdl_byte_t LINE_DATA_0_MASK  = 8'h63;
	localparam pdl_byte_t LINE_DATA_1_MASK  = 8'hff;
	localparam pdl_byte_t LINE_DATA_3_MASK  = 8'h0f;
	localparam pdl_byte_t LINE_DATA_4_MASK  = 8'hff;
	localparam pdl_byte_t LINE_DATA_5_MASK  = 8'hff;
	localparam pdl_byte_t LINE_DATA_6_MASK  = 8'hff;
	localparam pdl_byte_t LINE_DATA_7_MASK  = 8'h7f;
	localparam pdl_byte_t LINE_DATA_8_MASK  = 8'hff;
	localparam pdl_byte_t LINE_DATA_9_MASK  = 8'hff;
	localparam pdl_byte_t LINE_DATA_12_MASK = 8'h1f;
	localparam pdl_byte_t LINE_DATA_13_MASK = 8'h07;

	localparam pdl_byte_t LINE_DATA_RESET = 8'h00;

endpackage : pdl_pkg

// >>> rtl/pdl_port_data_latch_bank.sv
// Port data latch bank: eleven 8-bit output latches with pin drive and read-back.
// Assumes pin_direction_select comes from mode registers elsewhere; pins arrive asynchronously.
`timescale 1ns/1ps

//Contract
// - An output-mode bit drives its pin with its latch value.
// - Reading an input-mode bit returns the sampled pin level.
// - Reading an output-mode bit returns the latch value.
// - Registers take byte writes and single-bit writes touching only one bit.
// - Reset clears every output latch to zero.
// - Bit value 0 means low, 1 means high, both directions.
// - Direction select 0 enables output buffer; 1 selects input mode.
module pdl_port_data_latch_bank (
	// Clock and reset
	input  wire logic                                     core_clk,
	input  wire logic                                     rst,
	// Processor memory access
	input  wire pdl_pkg::pdl_addr_t                       cpu_addr,
	input  wire logic                                     cpu_rd,
	input  wire logic                                     cpu_wr,
	input  wire logic                                     cpu_bit_wr,
	input  wire logic [2:0]                               cpu_bit_sel,
	input  wire pdl_pkg::pdl_byte_t                       cpu_wdata,
	output pdl_pkg::pdl_byte_t                            cpu_rdata,
	// Direction select per bit from mode registers
	input  wire logic [pdl_pkg::PDL_NPORT-1:0][7:0]       pin_direction_select,
	// Port pins
	input  wire logic [pdl_pkg::PDL_NPORT-1:0][7:0]       pin_in,
	output logic      [pdl_pkg::PDL_NPORT-1:0][7:0]       pin_out,
	output logic      [pdl_pkg::PDL_NPORT-1:0][7:0]       pin_oe
);
	import pdl_pkg::*;

	typedef struct packed {
		logic [PDL_NPORT-1:0][7:0] latch;
		logic [PDL_NPORT-1:0][7:0] sync1;
		logic [PDL_NPORT-1:0][7:0] sync2;
		pdl_byte_t                 rdata;
	} pdl_state_t;

	pdl_state_t st_q;
	pdl_state_t st_d;

	// Address to bank index; hit low when unmapped
	function automatic logic [4:0] pdl_decode(input pdl_addr_t a);
		case (a)
			LINE_DATA_0_OFS:  pdl_decode = {1'b1, 4'h0};
			LINE_DATA_1_OFS:  pdl_decode = {1'b1, 4'h1};
			LINE_DATA_3_OFS:  pdl_decode = {1'b1, 4'h2};
			LINE_DATA_4_OFS:  pdl_decode = {1'b1, 4'h3};
			LINE_DATA_5_OFS:  pdl_decode = {1'b1, 4'h4};
			LINE_DATA_6_OFS:  pdl_decode = {1'b1, 4'h5};
			LINE_DATA_7_OFS:  pdl_decode = {1'b1, 4'h6};
			LINE_DATA_8_OFS:  pdl_decode = {1'b1, 4'h7};
			LINE_DATA_9_OFS:  pdl_decode = {1'b1, 4'h8};
			LINE_DATA_12_OFS: pdl_decode = {1'b1, 4'h9};
			LINE_DATA_13_OFS: pdl_decode = {1'b1, 4'ha};
			default:          pdl_decode = {1'b0, 4'h0};
		endcase
	endfunction : pdl_decode

	// Implemented-bit mask per bank index
	function automatic pdl_byte_t pdl_mask(input pdl_idx_t i);
		case (i)
			4'h0:    pdl_mask = LINE_DATA_0_MASK;
			4'h1:    pdl_mask = LINE_DATA_1_MASK;
			4'h2:    pdl_mask = LINE_DATA_3_MASK;
			4'h3:    pdl_mask = LINE_DATA_4_MASK;
			4'h4:    pdl_mask = LINE_DATA_5_MASK;
			4'h5:    pdl_mask = LINE_DATA_6_MASK;
			4'h6:    pdl_mask = LINE_DATA_7_MASK;
			4'h7:    pdl_mask = LINE_DATA_8_MASK;
			4'h8:    pdl_mask = LINE_DATA_9_MASK;
			4'h9:    pdl_mask = LINE_DATA_12_MASK;
			4'ha:    pdl_mask = LINE_DATA_13_MASK;
			default: pdl_mask = 8'h00;
		endcase
	endfunction : pdl_mask

	logic [4:0] dec;
	pdl_idx_t   idx;
	logic       hit;
	pdl_byte_t  msk;
	pdl_byte_t  cur;
	pdl_byte_t  view;

	always_comb begin
		dec  = pdl_decode(cpu_addr);
		hit  = dec[4];
		idx  = dec[3:0];
		msk  = pdl_mask(idx);
		cur  = st_q.latch[idx];
		// Per bit: input mode shows synced pin, output mode shows latch
		view = ((pin_direction_select[idx] & st_q.sync2[idx]) |
			(~pin_direction_select[idx] & cur)) & msk;
		st_d       = st_q;
		st_d.sync1 = pin_in;
		st_d.sync2 = st_q.sync1;
		if (hit && cpu_wr) begin
			st_d.latch[idx] = cpu_wdata & msk;
		end else if (hit && cpu_bit_wr) begin
			st_d.latch[idx][cpu_bit_sel] = cpu_wdata[0] & msk[cpu_bit_sel];
		end
		if (cpu_rd) begin
			st_d.rdata = hit ? view : 8'h00;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	always_comb begin
		cpu_rdata = st_q.rdata;
		for (int i = 0; i < PDL_NPORT; i++) begin
			pin_out[i] = st_q.latch[i];
			pin_oe[i]  = ~pin_direction_select[i] & pdl_mask(4'(i));
		end
	end

endmodule : pdl_port_data_latch_bank

// >>> test/pdl_port_data_latch_bank_asserts.sv
// Checker for the port data latch bank, watching ports 0 and 1
// Assumes it is bound to the bank top module
`timescale 1ns/1ps
module pdl_port_data_latch_bank_asserts import pdl_pkg::*; (
	input wire logic core_clk, rst, cpu_rd, cpu_wr, cpu_bit_wr,
	input wire logic [2:0] cpu_bit_sel,
	input wire pdl_addr_t cpu_addr,
	input wire pdl_byte_t cpu_wdata, cpu_rdata,
	input wire logic [PDL_NPORT-1:0][7:0] pin_direction_select, pin_in, pin_out, pin_oe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	oe_dir_a: assert property (pin_oe[1] == ~pin_direction_select[1]) else $error("oe");
	byte_wr_a: assert property (cpu_wr && cpu_addr == 16'hff01 |=> pin_out[1] == $past(cpu_wdata)) else $error("wr");
	bit_wr_a: assert property (cpu_bit_wr && !cpu_wr && cpu_addr == 16'hff01
		|=> pin_out[1][$past(cpu_bit_sel)] == $past(cpu_wdata[0])) else $error("bit");
	rst_clr_a: assert property (disable iff (1'b0) rst |-> pin_out == '0) else $error("rst");
	rd_out_a: assert property (cpu_rd && cpu_addr == 16'hff01 && pin_direction_select[1] == 8'h00
		|=> cpu_rdata == $past(pin_out[1])) else $error("rdo");
	rd_in_a: assert property ($stable(pin_in[1])[*3] ##0 (cpu_rd && cpu_addr == 16'hff01
		&& pin_direction_select[1] == 8'hff) |=> cpu_rdata == $past(pin_in[1])) else $error("rdi");
	mask_a: assert property (cpu_rd && cpu_addr == 16'hff00 |=> !(cpu_rdata & ~LINE_DATA_0_MASK)) else $error("m");
	unmap_a: assert property (cpu_rd && cpu_addr == 16'hff02 |=> cpu_rdata == 8'h00) else $error("u");
endmodule : pdl_port_data_latch_bank_asserts
bind pdl_port_data_latch_bank pdl_port_data_latch_bank_asserts u_chk (.core_clk, .rst, .cpu_rd, .cpu_wr,
	.cpu_bit_wr, .cpu_bit_sel, .cpu_addr, .cpu_wdata, .cpu_rdata, .pin_direction_select, .pin_in, .pin_out, .pin_oe);

// >>> test/pdl_pins_model.sv
// Pin model: driven pins echo the latch, released pins show the bench level
// Assumes pin_oe is high while the bank drives
`timescale 1ns/1ps
module pdl_pins_model import pdl_pkg::*; (
	input wire logic [PDL_NPORT-1:0][7:0] pin_out, pin_oe, ext_level,
	output logic [PDL_NPORT-1:0][7:0] pin_in
);
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : pdl_pins_model

// >>> test/pdl_port_data_latch_bank_tb_top.sv
// Self-checking bench for the port data latch bank
// Assumes the pin model and the bound checker
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module pdl_port_data_latch_bank_tb_top;
	import pdl_pkg::*;
	logic core_clk = 0, rst = 0, cpu_rd = 0, cpu_wr = 0, cpu_bit_wr = 0;
	logic [2:0] cpu_bit_sel = 0;
	pdl_addr_t cpu_addr = 0;
	pdl_byte_t cpu_wdata = 0, cpu_rdata;
	logic [PDL_NPORT-1:0][7:0] dsel = '1, ext = '0, pin_in, pin_out, pin_oe;
	int fails = 0, check_count = 0;
	always #20 core_clk = ~core_clk;
	pdl_port_data_latch_bank u_dut (.core_clk, .rst, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_bit_wr, .cpu_bit_sel,
		.cpu_wdata, .cpu_rdata, .pin_direction_select(dsel), .pin_in, .pin_out, .pin_oe);
	pdl_pins_model u_pins (.pin_out, .pin_oe, .ext_level(ext), .pin_in);
	task automatic op(input logic r, w, b, input pdl_addr_t a, input pdl_byte_t d, input logic [2:0] s);
		@(posedge core_clk); #1;
		{cpu_rd, cpu_wr, cpu_bit_wr, cpu_addr, cpu_wdata, cpu_bit_sel} = {r, w, b, a, d, s};
		@(posedge core_clk); #1;
		{cpu_rd, cpu_wr, cpu_bit_wr} = 3'h0;
	endtask : op
	task automatic t_out;
		dsel = '0;
		op(1, 0, 0, 16'hff0d, 8'h00, 0);
		`CHK(cpu_rdata, 8'h00)
		op(0, 1, 0, 16'hff01, 8'ha5, 0);
		op(1, 0, 0, 16'hff01, 8'h00, 0);
		`CHK(cpu_rdata, 8'ha5)
		`CHK(pin_oe[0], LINE_DATA_0_MASK)
	endtask : t_out
	task automatic t_bit;
		op(0, 0, 1, 16'hff01, 8'h01, 1);
		op(0, 0, 1, 16'hff01, 8'hfe, 7);
		`CHK(pin_out[1], 8'h27)
	endtask : t_bit
	task automatic t_in;
		dsel[1] = '1;
		ext[1] = 8'h3c;
		repeat (3) @(posedge core_clk);
		op(1, 0, 0, 16'hff01, 8'h00, 0);
		`CHK(cpu_rdata, 8'h3c)
	endtask : t_in
	task automatic t_mask;
		op(0, 1, 0, 16'hff00, 8'hff, 0);
		op(0, 1, 0, 16'hff0d, 8'h05, 0);
		op(1, 0, 0, 16'hff00, 8'h00, 0);
		`CHK(cpu_rdata, LINE_DATA_0_MASK)
		op(1, 0, 0, 16'hff02, 8'h00, 0);
		`CHK(cpu_rdata, 8'h00)
		op(1, 0, 0, 16'hff0d, 8'h00, 0);
		`CHK(cpu_rdata, 8'h05)
	endtask : t_mask
	task automatic t_reset;
		@(posedge core_clk);
		#1 rst = 1;
		repeat (2) @(posedge core_clk);
		#1 rst = 0;
		`CHK(pin_out, '0)
		`CHK(cpu_rdata, 8'h00)
		op(1, 0, 0, 16'hff00, 8'h00, 0);
		`CHK(cpu_rdata, 8'h00)
	endtask : t_reset
	task automatic complete_run;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : complete_run
	initial begin
		#1 rst = 1;
		repeat (8) @(posedge core_clk);
		#1 rst = 0;
		`CHK(pin_out, '0)
		t_out;
		t_bit;
		t_in;
		t_mask;
		t_reset;
		complete_run;
	end
endmodule : pdl_port_data_latch_bank_tb_top
